/* rtl/sfc4_pkg.sv */
// Shared constants, frame layout and serial CRC functions for both link ends.
// Assumes one clock domain; both ends import this package.
package sfc4_pkg;

    localparam int          FRAME_W       = 32;
    localparam int          SRC_NUM       = 8;
    localparam logic [3:0]  POLY4         = 4'h1;
    localparam logic [7:0]  POLY8         = 8'h2f;
    localparam logic [7:0]  SEED8_ZERO    = 8'hff;
    localparam logic [3:0]  SEED8_HI      = 4'hf;
    localparam logic [3:0]  CNT_RESET     = 4'h1;
    localparam logic [1:0]  BSTAT_ERROR   = 2'b11;
    // Command codes that ask for sensor data; source_identifier is code[2:0]
    localparam logic [15:0] SENSOR_CODES  = 16'h000e;

    // Frame field positions
    localparam int          CODE_LSB      = 28;
    localparam int          BSTAT_LSB     = 26;
    localparam int          IDX_LSB       = 16;
    localparam int          DATA_LSB      = 8;
    localparam int          SAMPLE_LSB    = 12;
    localparam int          RES_LSB       = 10;
    localparam int          DETAIL_LSB    = 8;
    localparam int          CNT_LSB       = 4;

    // Host register offsets
    localparam logic [7:0]  OFS_CTRL      = 8'h00;
    localparam logic [7:0]  OFS_CMD       = 8'h04;
    localparam logic [7:0]  OFS_RSP       = 8'h08;
    localparam logic [7:0]  OFS_STAT      = 8'h0c;
    localparam logic [7:0]  OFS_IRQ_STAT  = 8'h10;
    localparam logic [7:0]  OFS_IRQ_CLR   = 8'h14;
    localparam logic [7:0]  OFS_IRQ_EN    = 8'h18;
    localparam int          CTRL_MODE_BIT = 0;
    localparam int          CTRL_SEED_LSB = 4;
    localparam int          IRQ_DONE_BIT  = 0;
    localparam int          IRQ_ERR_BIT   = 1;

    // Serial x^4+1 CRC, MSB first, optionally followed by four zero bits
    function automatic logic [3:0] sfc4_crc4(input logic [31:0] frame,
                                             input logic [3:0]  seed,
                                             input logic        pad);
        logic [3:0] r;
        logic       fb;
        r = seed;
        for (int i = FRAME_W - 1; i >= 0; i--) begin
            fb = r[3] ^ frame[i];
            r  = {r[2:0], 1'b0} ^ (fb ? POLY4 : 4'h0);
        end
        for (int j = 0; j < 4; j++) begin
            if (pad) begin
                fb = r[3];
                r  = {r[2:0], 1'b0} ^ (fb ? POLY4 : 4'h0);
            end
        end
        return r;
    endfunction : sfc4_crc4

    // Serial default 8-bit CRC over 32 bits, MSB first, bits enter at the low end
    // Encoding runs over the frame with its CRC byte clear; checking a sound frame gives zero
    function automatic logic [7:0] sfc4_crc8(input logic [31:0] frame,
                                             input logic [7:0]  seed);
        logic [7:0] r;
        logic       fb;
        r = seed;
        for (int i = FRAME_W - 1; i >= 0; i--) begin
            fb = r[7];
            r  = {r[6:0], frame[i]} ^ (fb ? POLY8 : 8'h00);
        end
        return r;
    endfunction : sfc4_crc8

    function automatic logic [7:0] sfc4_seed8(input logic [3:0] seed);
        return (seed == 4'h0) ? SEED8_ZERO : {SEED8_HI, seed};
    endfunction : sfc4_seed8

endpackage : sfc4_pkg

/* rtl/sfc4_link_if.sv */
// Word-level link between host controller and device end.
// Assumes both ends share clk; each valid is a one-cycle pulse.
`timescale 1ns/10ps
interface sfc4_link_if;
    logic        cmd_valid;
    logic [31:0] cmd_frame;
    logic        rsp_valid;
    logic [31:0] rsp_frame;

    modport dev (
        input  cmd_valid,
        input  cmd_frame,
        output rsp_valid,
        output rsp_frame
    );
    modport host (
        output cmd_valid,
        output cmd_frame,
        input  rsp_valid,
        input  rsp_frame
    );
endinterface : sfc4_link_if

/* rtl/sfc4_dev_end.sv */
// Device end: checks command CRC, asks the sensor side, builds CRC'd responses.
// Assumes commands arrive as one-cycle pulses on the link and cfg inputs are on clk.
//
// Summary of operation
// (R1) Command CRC over all 32 bits, MSB first
// (R2) Bad CRC: drop command, send error response
// (R3) Preset shift register with crc_seed_field
// (R4) Shift message and CRC; zero means valid
// (R5) Command CRC polynomial x^4+1, programmable seed
// (R6) Response CRC: seed, 32 bits, four zeros
// (R7) Response CRC uses same polynomial and seed
// (R8) Insert message_counter at bits 7:4
// (R9) Per-source counter starts 0001, counts responses
// (R10) Register response layout with swapped echo
// (R11) Sensor response layout with sample and counter
// (R12) Error responses: status 11, echo rules
// (R13) CRC must reproduce the published vectors
// (R14) Host zeroes unused command fields
// (R15) Default 8-bit CRC unless 4-bit selected
// (R16) Counter wraps 1111 to 0000, resets 0001
//
// The APB register port and the address map are this design's own decisions.
`timescale 1ns/10ps
module sfc4_dev_end
    import sfc4_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        srst,
    sfc4_link_if.dev         link,
    input  wire logic        crc4_en,
    input  wire logic [3:0]  crc_seed,
    output logic             req_valid,
    output logic             req_sensor,
    output logic [3:0]       req_code,
    output logic [7:0]       req_index,
    output logic [7:0]       req_data,
    output logic [2:0]       req_source,
    output logic             crc_fail,
    input  wire logic        ans_valid,
    input  wire logic [1:0]  ans_status,
    input  wire logic [15:0] ans_content,
    input  wire logic [11:0] ans_sample,
    input  wire logic [1:0]  ans_resolution,
    input  wire logic [1:0]  ans_detail,
    input  wire logic        ans_error,
    input  wire logic        ans_has_data
);

    typedef enum logic [0:0] {
        SFC4_IDLE = 1'b0,
        SFC4_ASK  = 1'b1
    } sfc4_state_t;

    sfc4_state_t state_r;
    sfc4_state_t state_nxt;
    logic [3:0]  cnt_r [SRC_NUM];
    logic        req_valid_r;
    logic        req_sensor_r;
    logic [3:0]  req_code_r;
    logic [7:0]  req_index_r;
    logic [7:0]  req_data_r;
    logic [2:0]  req_source_r;
    logic        crc_fail_r;
    logic        rsp_valid_r;
    logic [31:0] rsp_frame_r;

    wire logic [31:0] cmd        = link.cmd_frame;
    wire logic [3:0]  cmd_code   = cmd[CODE_LSB+:4];
    wire logic [7:0]  seed8      = sfc4_seed8(crc_seed);
    // Checking runs over message and CRC together; a clean frame leaves zero
    wire logic [3:0]  chk4       = sfc4_crc4(cmd, crc_seed, 1'b0);      // [R1] [R3] [R4] [R5]
    wire logic [7:0]  chk8       = sfc4_crc8(cmd, seed8);               // [R15]
    wire logic        cmd_ok     = crc4_en ? (chk4 == 4'h0) : (chk8 == 8'h00); // [R4] [R13]
    wire logic        cmd_take   = (state_r == SFC4_IDLE) && link.cmd_valid;
    wire logic        cmd_good   = cmd_take && cmd_ok;
    wire logic        cmd_bad    = cmd_take && !cmd_ok;                 // [R2]
    wire logic        ans_fire   = (state_r == SFC4_ASK) && ans_valid;

    // Echoed code goes out as C0,C3,C2,C1
    wire logic [3:0]  echo       = {req_code_r[0], req_code_r[3], req_code_r[2],
                                    req_code_r[1]};                     // [R10]
    wire logic [1:0]  bstat      = ans_error ? BSTAT_ERROR : ans_status; // [R12]
    wire logic        no_data    = ans_error && !ans_has_data;
    wire logic [3:0]  cnt_now    = cnt_r[req_source_r];
    // A sensor error without data carries no counter
    wire logic [3:0]  cnt_field  = (crc4_en && !no_data) ? cnt_now : 4'h0; // [R8] [R12]

    wire logic [31:0] reg_body   = {ans_error ? 4'h0 : echo, bstat, 2'b00,
                                    ans_content, 8'h00};                // [R10] [R12]
    wire logic [31:0] sen_body   = {no_data ? 4'h0 : echo, bstat, 2'b00,
                                    no_data ? 12'h000 : ans_sample,
                                    no_data ? 2'b00 : ans_resolution,
                                    ans_detail, cnt_field, 4'h0};       // [R11] [R12] [R8]
    wire logic [31:0] err_body   = {4'h0, BSTAT_ERROR, 26'h0};          // [R2] [R12]
    wire logic [31:0] body       = cmd_bad ? err_body :
                                   (req_sensor_r ? sen_body : reg_body);

    // Encoding: body with CRC field clear; the 4-bit CRC then takes four zero pad bits
    wire logic [3:0]  enc4       = sfc4_crc4(body, crc_seed, 1'b1);     // [R6] [R7]
    wire logic [7:0]  enc8       = sfc4_crc8({body[31:8], 8'h00}, seed8); // [R15]
    wire logic [31:0] rsp_nxt    = crc4_en ? {body[31:4], enc4} : {body[31:8], enc8};

    wire logic        cnt_step   = ans_fire && req_sensor_r && crc4_en; // [R9]

    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            SFC4_IDLE: begin
                if (cmd_good) begin
                    state_nxt = SFC4_ASK;
                end
            end
            SFC4_ASK: begin
                if (ans_fire) begin
                    state_nxt = SFC4_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            state_r <= SFC4_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    // Only commands that pass the check reach the sensor side
    always_ff @(posedge clk) begin
        if (srst) begin
            req_valid_r  <= 1'b0;
            req_sensor_r <= 1'b0;
            req_code_r   <= 4'h0;
            req_index_r  <= 8'h00;
            req_data_r   <= 8'h00;
            req_source_r <= 3'h0;
        end else begin
            req_valid_r <= cmd_good;                                    // [R2]
            if (cmd_good) begin
                req_sensor_r <= SENSOR_CODES[cmd_code];
                req_code_r   <= cmd_code;
                req_index_r  <= cmd[IDX_LSB+:8];
                req_data_r   <= cmd[DATA_LSB+:8];
                req_source_r <= cmd_code[2:0];
            end
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            rsp_valid_r <= 1'b0;
            rsp_frame_r <= 32'h0000_0000;
            crc_fail_r  <= 1'b0;
        end else begin
            rsp_valid_r <= cmd_bad || ans_fire;
            crc_fail_r  <= cmd_bad;
            if (cmd_bad || ans_fire) begin
                rsp_frame_r <= rsp_nxt;
            end
        end
    end

    // Counters wrap in 4 bits; a source counts only its own responses
    always_ff @(posedge clk) begin
        for (int s = 0; s < SRC_NUM; s++) begin
            if (srst) begin
                cnt_r[s] <= CNT_RESET;                                  // [R16]
            end else if (cnt_step && (req_source_r == 3'(s))) begin
                cnt_r[s] <= cnt_r[s] + 4'h1;                            // [R9] [R16]
            end
        end
    end

    assign req_valid      = req_valid_r;
    assign req_sensor     = req_sensor_r;
    assign req_code       = req_code_r;
    assign req_index      = req_index_r;
    assign req_data       = req_data_r;
    assign req_source     = req_source_r;
    assign crc_fail       = crc_fail_r;
    assign link.rsp_valid = rsp_valid_r;
    assign link.rsp_frame = rsp_frame_r;

endmodule : sfc4_dev_end

/* rtl/sfc4_host_end.sv */
// Host controller end: APB registers, builds CRC'd commands, checks responses.
// Assumes an APB master on clk and the device end on the other side of the link.
`timescale 1ns/10ps
module sfc4_host_end
    import sfc4_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        srst,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    output logic             irq,
    sfc4_link_if.host        link
);

    logic        pready_r;
    logic [31:0] prdata_r;
    logic        mode_r;
    logic [3:0]  seed_r;
    logic [31:0] cmd_r;
    logic [31:0] rsp_r;
    logic        busy_r;
    logic        rsp_ok_r;
    logic [1:0]  ist_r;
    logic [1:0]  ien_r;
    logic        irq_r;
    logic        cmd_valid_r;

    wire logic        acc      = psel && penable;
    wire logic        wr_fire  = acc && pready_r && pwrite;
    wire logic        wr_ctrl  = wr_fire && (paddr == OFS_CTRL);
    wire logic        wr_cmd   = wr_fire && (paddr == OFS_CMD) && !busy_r;
    wire logic        wr_clr   = wr_fire && (paddr == OFS_IRQ_CLR);
    wire logic        wr_en    = wr_fire && (paddr == OFS_IRQ_EN);
    wire logic [3:0]  code     = pwdata[CODE_LSB+:4];
    wire logic        sensor   = SENSOR_CODES[code];
    // Sensor-data commands go out with every field but the code cleared
    wire logic [31:0] body     = {code, 4'h0, sensor ? 16'h0000 : pwdata[DATA_LSB+:16],
                                  8'h00};                               // [R14]
    wire logic [3:0]  enc4     = sfc4_crc4(body, seed_r, 1'b1);         // [R1] [R3] [R5]
    wire logic [7:0]  enc8     = sfc4_crc8(body, sfc4_seed8(seed_r));
    wire logic [31:0] frame    = mode_r ? {body[31:4], enc4} : {body[31:8], enc8};
    wire logic        rsp_ok   = mode_r ? (sfc4_crc4(link.rsp_frame, seed_r, 1'b0) == 4'h0)
                                        : (sfc4_crc8(link.rsp_frame, sfc4_seed8(seed_r))
                                           == 8'h00);                   // [R7] [R13]
    wire logic        rsp_take = busy_r && link.rsp_valid;
    wire logic [1:0]  ev       = {rsp_take && !rsp_ok, rsp_take};
    wire logic [31:0] rd_mux   = (paddr == OFS_CTRL)     ? {24'h0, seed_r, 3'h0, mode_r} :
                                 (paddr == OFS_CMD)      ? cmd_r :
                                 (paddr == OFS_RSP)      ? rsp_r :
                                 (paddr == OFS_STAT)     ? {30'h0, rsp_ok_r, busy_r} :
                                 (paddr == OFS_IRQ_STAT) ? {30'h0, ist_r} :
                                 (paddr == OFS_IRQ_EN)   ? {30'h0, ien_r} : 32'h0000_0000;

    // One wait state keeps prdata registered
    always_ff @(posedge clk) begin
        if (srst) begin
            pready_r <= 1'b0;
            prdata_r <= 32'h0000_0000;
        end else begin
            pready_r <= acc && !pready_r;
            if (acc && !pready_r) begin
                prdata_r <= rd_mux;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            mode_r <= 1'b0;
            seed_r <= 4'h0;
            ien_r  <= 2'b00;
        end else begin
            if (wr_ctrl) begin
                mode_r <= pwdata[CTRL_MODE_BIT];
                seed_r <= pwdata[CTRL_SEED_LSB+:4];
            end
            if (wr_en) begin
                ien_r <= pwdata[1:0];
            end
        end
    end

    // A command written while busy is dropped
    always_ff @(posedge clk) begin
        if (srst) begin
            cmd_r       <= 32'h0000_0000;
            cmd_valid_r <= 1'b0;
            busy_r      <= 1'b0;
            rsp_r       <= 32'h0000_0000;
            rsp_ok_r    <= 1'b0;
        end else begin
            cmd_valid_r <= wr_cmd;
            if (wr_cmd) begin
                cmd_r  <= frame;
                busy_r <= 1'b1;
            end else if (rsp_take) begin
                busy_r <= 1'b0;
            end
            if (rsp_take) begin
                rsp_r    <= link.rsp_frame;
                rsp_ok_r <= rsp_ok;
            end
        end
    end

    // New events win over a clear in the same cycle
    always_ff @(posedge clk) begin
        if (srst) begin
            ist_r <= 2'b00;
            irq_r <= 1'b0;
        end else begin
            ist_r <= (ist_r & ~(wr_clr ? pwdata[1:0] : 2'b00)) | ev;
            irq_r <= |(((ist_r & ~(wr_clr ? pwdata[1:0] : 2'b00)) | ev) & ien_r);
        end
    end

    assign prdata         = prdata_r;
    assign pready         = pready_r;
    assign pslverr        = 1'b0;
    assign irq            = irq_r;
    assign link.cmd_valid = cmd_valid_r;
    assign link.cmd_frame = cmd_r;

endmodule : sfc4_host_end

/* dv/sfc4_assertions.sv */
// Link checker: CRC seal, error frames, pad bits and per-source counters.
// Assumes the device's mode and seed inputs are wired in beside the link.
`timescale 1ns/10ps
module sfc4_assertions (
    input wire logic        clk,
    input wire logic        srst,
    input wire logic        cmd_valid,
    input wire logic [31:0] cmd_frame,
    input wire logic        rsp_valid,
    input wire logic [31:0] rsp_frame,
    input wire logic        crc4_en,
    input wire logic [3:0]  crc_seed
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);
    // x^4+1 reduces to a nibble XOR, so a sound frame folds to the seed
    function automatic logic [3:0] fold(input logic [31:0] f);
        return f[31:28] ^ f[27:24] ^ f[23:20] ^ f[19:16] ^ f[15:12] ^ f[11:8] ^ f[7:4] ^ f[3:0];
    endfunction : fold
    logic [3:0] cnt_r [8];
    wire        cmd_bad = crc4_en && (fold(cmd_frame) != crc_seed);
    wire [3:0]  echo    = rsp_frame[31:28];
    wire        rsp_sns = crc4_en && (echo == 4'h8 || echo == 4'h1 || echo == 4'h9);
    wire [2:0]  src     = {echo[1:0], echo[3]};
    // Tracks by echo only; a sensor error without data escapes this view
    always_ff @(posedge clk) begin
        for (int i = 0; i < 8; i++) begin
            if (srst) begin
                cnt_r[i] <= 4'h1;
            end else if (rsp_valid && rsp_sns && src == i[2:0]) begin
                cnt_r[i] <= cnt_r[i] + 4'h1;
            end
        end
    end
    chk_bad_cmd_err: assert property (cmd_valid && cmd_bad |=>
        rsp_valid && rsp_frame[31:4] == 28'h0c00000) else $error("no error frame");
    chk_good_cmd_quiet: assert property (cmd_valid && crc4_en && !cmd_bad |=>
        !rsp_valid) else $error("sound command answered at once");
    chk_rsp_crc_seal: assert property (rsp_valid && crc4_en |->
        fold(rsp_frame) == crc_seed) else $error("response CRC wrong");
    chk_reg_pad_zero: assert property (rsp_valid && crc4_en && !rsp_sns |->
        rsp_frame[25:24] == 2'b00 && rsp_frame[7:4] == 4'h0) else $error("pad bits set");
    chk_cnt_per_src: assert property (rsp_valid && rsp_sns |->
        rsp_frame[7:4] == cnt_r[src]) else $error("message counter wrong");
    chk_cmd_fixed_zero: assert property (cmd_valid && crc4_en |->
        cmd_frame[27:24] == 4'h0 && cmd_frame[7:4] == 4'h0) else $error("command pad set");
    chk_sns_cmd_zero: assert property (cmd_valid && crc4_en && cmd_frame[31:28] inside {1, 2, 3} |->
        cmd_frame[27:4] == 24'h0) else $error("sensor command not blank");
    chk_rsp_frame_hold: assert property (!rsp_valid |->
        $stable(rsp_frame)) else $error("response word moved");
    cov_bad_cmd: cover property (cmd_valid && cmd_bad);
    cov_cnt_wrap: cover property (rsp_valid && rsp_sns && rsp_frame[7:4] == 4'h0);
    cov_reg_rsp: cover property (rsp_valid && crc4_en && !rsp_sns);
endmodule : sfc4_assertions

/* dv/spi_frame_crc4_with_counter_bench.sv */
// Bench: host end and device end joined by the link; bench is APB master and sensor side.
// Assumes one 50 MHz clock and synchronous reset.
`timescale 1ns/10ps
module spi_frame_crc4_with_counter_bench import sfc4_pkg::*; ;
    logic        clk = 1'b0, srst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata;
    logic        pready, pslverr, irq, crc4_en = 1'b0, ans_valid = 1'b0, ans_error = 1'b0;
    logic        ans_has_data = 1'b0, req_valid, req_sensor, crc_fail;
    logic [3:0]  crc_seed = 4'h0, req_code, hseed, dseed;
    logic [7:0]  req_index, req_data;
    logic [2:0]  req_source;
    logic [1:0]  ans_status = 2'b00, ans_resolution = 2'b00, ans_detail = 2'b00;
    logic [15:0] ans_content = 16'h0;
    logic [11:0] ans_sample = 12'h0;
    logic        m4 = 1'b0;
    logic [3:0]  msg_cnt [8] = '{default: 4'h1};
    logic [23:0] vt [7] = '{24'h822c1f, 24'h41fc1d, 24'hc22006, 24'h61fc1f, 24'h4ff5a1,
                            24'hc3e00b, 24'h6ff5a3};
    int          seed = 79576, err_count = 0, samples_checked = 0;
    always #10 clk = ~clk;
    sfc4_link_if link ();
    wire [2:0] ev = {link.rsp_valid, req_valid, link.cmd_valid};
    sfc4_host_end sfc4_host_end_i (.clk, .srst, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .irq, .link(link));
    sfc4_dev_end sfc4_dev_end_i (.clk, .srst, .link(link), .crc4_en, .crc_seed, .req_valid,
        .req_sensor, .req_code, .req_index, .req_data, .req_source, .crc_fail, .ans_valid,
        .ans_status, .ans_content, .ans_sample, .ans_resolution, .ans_detail, .ans_error,
        .ans_has_data);
    sfc4_assertions sfc4_assertions_i (.clk, .srst, .cmd_valid(link.cmd_valid),
        .cmd_frame(link.cmd_frame), .rsp_valid(link.rsp_valid), .rsp_frame(link.rsp_frame),
        .crc4_en, .crc_seed);
    task automatic test_done();
        $display("checks %0d errors %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : test_done
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            err_count++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    // Nibble-fold form of the x^4+1 encoder, seed included
    function automatic logic [31:0] seal(input logic [31:0] f, input logic [3:0] s);
        return {f[31:4], s ^ f[31:28] ^ f[27:24] ^ f[23:20] ^ f[19:16] ^ f[15:12] ^ f[11:8]
                ^ f[7:4]};
    endfunction : seal
    function automatic logic [31:0] rsp_of(input logic [3:0] c, input logic sn);
        logic [3:0] ec;
        logic [1:0] bs;
        ec = (ans_error && !(sn && ans_has_data)) ? 4'h0 : {c[0], c[3:1]};
        bs = ans_error ? 2'b11 : ans_status;
        if (!sn) return {ec, bs, 2'b00, ans_content, 8'h0};
        if (ans_error && !ans_has_data) return {8'h0c, 14'h0, ans_detail, 8'h0};
        return {ec, bs, 2'b00, ans_sample, ans_resolution, ans_detail,
                m4 ? msg_cnt[c[2:0]] : 4'h0, 4'h0};
    endfunction : rsp_of
    task automatic wait_ev(input int b);
        for (int n = 0; n < 40; n++) begin
            @(posedge clk);
            if (ev[b] === 1'b1) return;
        end
        err_count++;
        test_done();
    endtask : wait_ev
    // Request held from setup until pready is seen high at a rising edge
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                       output logic [31:0] rd);
        @(posedge clk);
        psel    <= 1'b1;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= wd;
        @(posedge clk);
        penable <= 1'b1;
        for (int n = 0; n < 20; n++) begin
            @(posedge clk);
            if (pready === 1'b1) begin
                rd = prdata;
                psel    <= 1'b0;
                penable <= 1'b0;
                return;
            end
        end
        err_count++;
        test_done();
    endtask : apb
    task automatic cfg(input logic m, input logic [3:0] hs, input logic [3:0] ds);
        logic [31:0] r;
        apb(1'b1, OFS_CTRL, {24'h0, hs, 3'h0, m}, r);
        m4 = m;
        hseed = hs;
        dseed = ds;
        crc4_en  <= m;
        crc_seed <= ds;
    endtask : cfg
    task automatic rnd(input logic er, input logic hd);
        logic [31:0] v;
        v = $random(seed);
        ans_status     <= v[1:0];
        ans_resolution <= v[3:2];
        ans_detail     <= v[5:4];
        ans_content    <= v[31:16];
        ans_sample     <= v[27:16];
        ans_error      <= er;
        ans_has_data   <= hd;
    endtask : rnd
    task automatic xact(input logic [3:0] c, input logic [15:0] id, input logic bad);
        logic [31:0] r;
        logic [31:0] e;
        logic        sn;
        sn = c inside {4'h1, 4'h2, 4'h3};
        e  = {c, 4'h0, sn ? 16'h0 : id, 8'h0};
        apb(1'b1, OFS_CMD, {c, 4'h0, id, 8'h0}, r);
        wait_ev(0);
        check(m4 ? link.cmd_frame : {link.cmd_frame[31:8], 8'h0},
              m4 ? seal(e, hseed) : e);
        if (bad) begin
            wait_ev(2);
            check({31'h0, crc_fail}, 32'h1);
            e = 32'h0c000000;
        end else begin
            wait_ev(1);
            check({8'h0, req_sensor, req_code, req_index, req_data, req_source},
                  {8'h0, sn, c, e[23:8], c[2:0]});
            ans_valid <= 1'b1;
            @(posedge clk);
            ans_valid <= 1'b0;
            wait_ev(2);
            e = rsp_of(c, sn);
        end
        check(m4 ? link.rsp_frame : {link.rsp_frame[31:8], 8'h0},
              m4 ? seal(e, dseed) : e);
        if (sn && m4 && !bad) msg_cnt[c[2:0]] = msg_cnt[c[2:0]] + 4'h1;
        apb(1'b0, OFS_STAT, 32'h0, r);
        check(r & 32'h3, {30'h0, hseed == dseed, 1'b0});
    endtask : xact
    initial begin
        logic [31:0] r;
        logic [23:0] v;
        repeat (6) @(posedge clk);
        srst <= 1'b0;
        apb(1'b0, 8'h1c, 32'h0, r);
        check(r, 32'h0);
        cfg(1'b1, 4'ha, 4'ha);
        for (int i = 0; i < 7; i++) begin
            v = vt[i];
            rnd(1'b0, 1'b1);
            xact(v[23:20], v[19:4], 1'b0);
            check({28'h0, link.cmd_frame[3:0]}, {28'h0, v[3:0]});
        end
        apb(1'b1, OFS_IRQ_EN, 32'h3, r);
        repeat (2) @(posedge clk);
        check({31'h0, irq}, 32'h1);
        apb(1'b1, OFS_IRQ_CLR, 32'h3, r);
        apb(1'b0, OFS_IRQ_STAT, 32'h0, r);
        check(r, 32'h0);
        check({31'h0, irq}, 32'h0);
        apb(1'b1, OFS_IRQ_EN, 32'h2, r);
        rnd(1'b0, 1'b1);
        xact(4'h7, 16'h1234, 1'b0);
        check({31'h0, irq}, 32'h0);
        // Seeds disagree, so the device refuses and the host flags the reply
        cfg(1'b1, 4'h5, 4'ha);
        xact(4'h9, 16'ha55a, 1'b1);
        apb(1'b0, OFS_IRQ_STAT, 32'h0, r);
        check(r & 32'h2, 32'h2);
        check({31'h0, irq}, 32'h1);
        apb(1'b1, OFS_IRQ_CLR, 32'h3, r);
        cfg(1'b1, 4'ha, 4'ha);
        rnd(1'b1, 1'b1);
        xact(4'h5, 16'h3c3c, 1'b0);
        rnd(1'b1, 1'b1);
        xact(4'h2, 16'h0, 1'b0);
        for (int i = 0; i < 17; i++) begin
            rnd(1'b0, 1'b1);
            xact(4'h1, 16'h0, 1'b0);
        end
        for (int i = 0; i < 30; i++) begin
            r = $random(seed);
            rnd(r[31:29] == 3'h0, 1'b1);
            xact(r[3:0], r[23:8], 1'b0);
        end
        cfg(1'b0, 4'ha, 4'ha);
        rnd(1'b0, 1'b1);
        xact(4'h2, 16'h0, 1'b0);
        // Zero seed field selects the all-ones 8-bit seed
        cfg(1'b0, 4'h0, 4'h0);
        xact(4'h8, 16'h22c1, 1'b0);
        check({24'h0, link.cmd_frame[7:0]}, 32'hbd);
        cfg(1'b1, 4'ha, 4'ha);
        xact(4'h2, 16'h0, 1'b0);
        rnd(1'b1, 1'b0);
        xact(4'h3, 16'h0, 1'b0);
        test_done();
    end
endmodule : spi_frame_crc4_with_counter_bench
